/* File: design/hbbls_pkg.sv */
// Shared constants and types for the host bus byte lane steering block.
// Assumes one 100 MHz system clock and host pins sampled synchronously to it.
package hbbls_pkg;
	localparam int ADDR_W = 6;
	localparam int OFF_W = 5;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [OFF_W-1:0] OFF_DATA_PORT = 5'h10;
	localparam logic [OFF_W-1:0] OFF_UNUSED = 5'h11;
	localparam logic [OFF_W-1:0] OFF_HALF_WORD = 5'h1E;
	localparam logic [OFF_W-1:0] OFF_DEV_RESET = 5'h1F;
	localparam logic [DATA_W-1:0] BUS_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
	localparam logic [OFF_W-1:0] OFF_RST = 5'h00;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [BYTE_W-1:0] BYTE_UNDEF = 8'h00;
	typedef enum logic [1:0] {
		HBBLS_MODE_ISA,
		HBBLS_MODE_PROC16,
		HBBLS_MODE_MCU8
	} hbbls_mode_t;
	typedef enum logic [1:0] {
		HBBLS_ST_IDLE,
		HBBLS_ST_READ,
		HBBLS_ST_WRITE
	} hbbls_state_t;
endpackage

/* File: design/hbbls_lane_if.sv */
// Carrier between the port core and the lane map.
// Assumes purely combinational use inside one clock domain.
`timescale 1ns/100ps
interface hbbls_lane_if;
	hbbls_pkg::hbbls_mode_t mode;
	logic [hbbls_pkg::ADDR_W-1:0] addr;
	logic [hbbls_pkg::DATA_W-1:0] wr_data;
	logic [hbbls_pkg::OFF_W-1:0] lo_off;
	logic [hbbls_pkg::OFF_W-1:0] hi_off;
	logic [hbbls_pkg::OFF_W-1:0] wr_off;
	logic [hbbls_pkg::BYTE_W-1:0] wr_byte;
	logic is_dp;
	logic is_reset_off;
	logic is_unused;
	logic hi_undef;
	modport core (
		output mode,
		output addr,
		output wr_data,
		input lo_off,
		input hi_off,
		input wr_off,
		input wr_byte,
		input is_dp,
		input is_reset_off,
		input is_unused,
		input hi_undef
	);
	modport map (
		input mode,
		input addr,
		input wr_data,
		output lo_off,
		output hi_off,
		output wr_off,
		output wr_byte,
		output is_dp,
		output is_reset_off,
		output is_unused,
		output hi_undef
	);
endinterface

/* File: design/hbbls_lane_map.sv */
// Combinational byte lane steering from host address to register offsets.
// Assumes mode and address are stable while they are used.
`timescale 1ns/100ps
module hbbls_lane_map (
	hbbls_lane_if.map lm
);
	import hbbls_pkg::*;
	logic proc;
	logic odd;
	always_comb begin
		proc = (lm.mode == HBBLS_MODE_PROC16);
		odd = lm.addr[0];
		// [R03] Even pairs N,N+1
		lm.lo_off = lm.addr[OFF_W-1:0];
		// [R05] Word aligned pair
		if (proc) begin
			lm.lo_off = {lm.addr[OFF_W-1:1], 1'b0};
		end
		// Odd reads give N itself in ISA mode, and N|1 is N there
		lm.hi_off = {lm.addr[OFF_W-1:1], 1'b1};
		lm.wr_off = lm.addr[OFF_W-1:0];
		// [R05] Odd write high lane
		lm.wr_byte = (proc && odd) ? lm.wr_data[DATA_W-1:BYTE_W] : lm.wr_data[BYTE_W-1:0];
		// [R09] Burst window decode
		lm.is_dp = lm.addr[ADDR_W-1] || (lm.addr[OFF_W-1:0] == OFF_DATA_PORT);
		lm.is_reset_off = !lm.addr[ADDR_W-1] && (lm.addr[OFF_W-1:0] == OFF_DEV_RESET);
		// [R07] Unused and half offsets
		lm.is_unused = !lm.addr[ADDR_W-1] && (lm.addr[OFF_W-1:0] == OFF_UNUSED);
		lm.hi_undef = !lm.addr[ADDR_W-1] && (lm.addr[OFF_W-1:0] == OFF_HALF_WORD);
	end
endmodule

/* File: design/hbbls_port.sv */
// Host parallel port: strobe handling, strap mode select and register steering.
// Assumes host pins synchronous to clk_sys and register data valid combinationally.
//
// Overview of operation
// [R01] Host address 0..5, enable, 16-bit data and strobes wire straight in.
// [R02] No strap pull-ups selects ISA-like mode.
// [R03] ISA reads: even gives N and N+1, odd gives N twice; writes low byte.
// [R04] Only clock strap pulled up selects 16-bit processor mode.
// [R05] Processor mode reads word pair; even writes low lane, odd writes high.
// [R06] Reading offset 1Fh resets the device; writing it only stores.
// [R07] Offset 10h is data port, 11h unused, high byte of 1Eh undefined.
// [R08] Both straps pulled up selects 8-bit microcontroller mode.
// [R09] Address bit 5 high opens the burst data window for word reads.
// [R10] Offset 10h is the packet data port to buffer memory.
`timescale 1ns/100ps
module hbbls_port (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic host_addr_bit0_in,
	input wire logic [3:0] host_addr_mid,
	input wire logic addr_bit5_burst_window_select,
	input wire logic address_enable_in,
	input wire logic [hbbls_pkg::DATA_W-1:0] host_data_bus_in,
	output logic [hbbls_pkg::DATA_W-1:0] host_data_bus_out,
	output logic host_data_bus_oe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic eeprom_select_strap_pin,
	input wire logic eeprom_clock_strap_pin,
	output hbbls_pkg::hbbls_mode_t bus_mode,
	output logic [hbbls_pkg::OFF_W-1:0] csr_lo_addr,
	output logic [hbbls_pkg::OFF_W-1:0] csr_hi_addr,
	input wire logic [hbbls_pkg::BYTE_W-1:0] csr_lo_data,
	input wire logic [hbbls_pkg::BYTE_W-1:0] csr_hi_data,
	output logic csr_wr_en,
	output logic [hbbls_pkg::OFF_W-1:0] csr_wr_addr,
	output logic [hbbls_pkg::BYTE_W-1:0] csr_wr_data,
	output logic dp_rd_next,
	input wire logic [hbbls_pkg::DATA_W-1:0] dp_rd_data,
	output logic dp_wr,
	output logic [hbbls_pkg::DATA_W-1:0] dp_wr_data,
	output logic device_reset
);
	import hbbls_pkg::*;

	typedef struct packed {
		hbbls_state_t st;
		hbbls_mode_t mode;
		logic mode_valid;
		logic [ADDR_W-1:0] addr_q;
		logic [DATA_W-1:0] wdata_q;
		logic [DATA_W-1:0] bus_out;
		logic bus_oe;
		logic wr_en;
		logic [OFF_W-1:0] wr_addr;
		logic [BYTE_W-1:0] wr_data;
		logic dp_next;
		logic dp_we;
		logic [DATA_W-1:0] dp_wdata;
		logic dev_rst;
	} hbbls_state_s_t;

	hbbls_state_s_t s;
	hbbls_state_s_t next_s;
	hbbls_lane_if lane ();
	logic [ADDR_W-1:0] addr_now;
	logic sel;
	logic rd_req;
	logic wr_req;

	hbbls_lane_map u_map (
		.lm(lane)
	);

	// [R01] Six address inputs
	assign addr_now = {addr_bit5_burst_window_select, host_addr_mid, host_addr_bit0_in};
	// Enable low qualifies a cycle, so DMA cycles on an ISA bus are ignored
	assign sel = !address_enable_in && s.mode_valid;
	assign rd_req = sel && !read_strobe_n;
	assign wr_req = sel && !write_strobe_n;

	// Writes are steered from the captured address, reads from the live one
	assign lane.mode = s.mode;
	assign lane.addr = (s.st == HBBLS_ST_WRITE) ? s.addr_q : addr_now;
	assign lane.wr_data = s.wdata_q;

	assign csr_lo_addr = lane.lo_off;
	assign csr_hi_addr = lane.hi_off;
	assign bus_mode = s.mode;
	assign host_data_bus_out = s.bus_out;
	assign host_data_bus_oe = s.bus_oe;
	assign csr_wr_en = s.wr_en;
	assign csr_wr_addr = s.wr_addr;
	assign csr_wr_data = s.wr_data;
	assign dp_rd_next = s.dp_next;
	assign dp_wr = s.dp_we;
	assign dp_wr_data = s.dp_wdata;
	assign device_reset = s.dev_rst;

	always_comb begin
		next_s = s;
		next_s.wr_en = 1'b0;
		next_s.dp_next = 1'b0;
		next_s.dp_we = 1'b0;
		next_s.dev_rst = 1'b0;
		// Straps are caught by the first edge after reset release
		if (!s.mode_valid) begin
			next_s.mode_valid = 1'b1;
			case ({eeprom_select_strap_pin, eeprom_clock_strap_pin})
				// [R04] Clock strap only
				2'b01: next_s.mode = HBBLS_MODE_PROC16;
				// [R08] Both straps
				2'b11: next_s.mode = HBBLS_MODE_MCU8;
				// [R02] No pull-ups
				default: next_s.mode = HBBLS_MODE_ISA;
			endcase
		end
		// Read data is registered every cycle from the combinational register inputs
		next_s.bus_out[BYTE_W-1:0] = csr_lo_data;
		next_s.bus_out[DATA_W-1:BYTE_W] = csr_hi_data;
		// [R10] Data port word
		if (lane.is_dp) begin
			next_s.bus_out = dp_rd_data;
		end
		// [R07] Undefined lanes read zero
		if (lane.is_unused) begin
			next_s.bus_out = {BYTE_UNDEF, BYTE_UNDEF};
		end
		if (lane.hi_undef) begin
			next_s.bus_out[DATA_W-1:BYTE_W] = BYTE_UNDEF;
		end
		case (s.st)
			HBBLS_ST_IDLE: begin
				next_s.bus_oe = 1'b0;
				if (rd_req) begin
					next_s.st = HBBLS_ST_READ;
					next_s.bus_oe = 1'b1;
					next_s.addr_q = addr_now;
					// [R06] Read resets device
					next_s.dev_rst = lane.is_reset_off;
				end else if (wr_req) begin
					next_s.st = HBBLS_ST_WRITE;
					next_s.addr_q = addr_now;
					next_s.wdata_q = host_data_bus_in;
				end
			end
			HBBLS_ST_READ: begin
				next_s.addr_q = addr_now;
				if (!rd_req) begin
					next_s.st = HBBLS_ST_IDLE;
					next_s.bus_oe = 1'b0;
					// Data port pointer advances as the word is released, and on a burst address change while the strobe is held
					next_s.dp_next = (s.addr_q[ADDR_W-1] || (s.addr_q[OFF_W-1:0] == OFF_DATA_PORT));
				end else if (addr_now != s.addr_q && s.addr_q[ADDR_W-1] && addr_now[ADDR_W-1]) begin
					// [R09] Burst word advance
					next_s.dp_next = 1'b1;
				end
			end
			HBBLS_ST_WRITE: begin
				if (wr_req) begin
					next_s.wdata_q = host_data_bus_in;
				end else begin
					next_s.st = HBBLS_ST_IDLE;
					if (lane.is_dp) begin
						// [R10] Data port write
						next_s.dp_we = 1'b1;
						next_s.dp_wdata = s.wdata_q;
					end else if (!lane.is_unused) begin
						// [R06] Write only stores
						next_s.wr_en = 1'b1;
						next_s.wr_addr = lane.wr_off;
						// [R03] Single lane write
						next_s.wr_data = lane.wr_byte;
					end
				end
			end
			default: begin
				next_s.st = HBBLS_ST_IDLE;
				next_s.bus_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s.st <= HBBLS_ST_IDLE;
			s.mode <= HBBLS_MODE_ISA;
			s.mode_valid <= 1'b0;
			s.addr_q <= ADDR_RST;
			s.wdata_q <= BUS_RST;
			s.bus_out <= BUS_RST;
			s.bus_oe <= 1'b0;
			s.wr_en <= 1'b0;
			s.wr_addr <= OFF_RST;
			s.wr_data <= BYTE_RST;
			s.dp_next <= 1'b0;
			s.dp_we <= 1'b0;
			s.dp_wdata <= BUS_RST;
			s.dev_rst <= 1'b0;
		end else begin
			s <= next_s;
		end
	end
endmodule

/* File: sim/hbbls_csr_model.sv */
// Register file and data port stand-in behind the host port.
// Assumes one clock; each byte is a fixed pattern of its offset.
`timescale 1ns/100ps
module hbbls_csr_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [4:0] csr_lo_addr,
	input wire logic [4:0] csr_hi_addr,
	output logic [7:0] csr_lo_data,
	output logic [7:0] csr_hi_data,
	input wire logic dp_rd_next,
	output logic [15:0] dp_rd_data
);
	assign csr_lo_data = {3'h5, csr_lo_addr};
	assign csr_hi_data = {3'h5, csr_hi_addr};
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			dp_rd_data <= 16'hD000;
		else if (dp_rd_next)
			dp_rd_data <= dp_rd_data + 16'h0001;
	end
endmodule

/* File: sim/hbbls_port_properties.sv */
// Timing and steering checks on the host port pins.
// Assumes strobes are sampled on the rising edge of clk_sys.
`timescale 1ns/100ps
module hbbls_port_properties (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic address_enable_in,
	input wire logic addr_bit5_burst_window_select,
	input hbbls_pkg::hbbls_mode_t bus_mode,
	input wire logic host_data_bus_oe,
	input wire logic [4:0] csr_lo_addr,
	input wire logic [4:0] csr_hi_addr,
	input wire logic csr_wr_en,
	input wire logic device_reset,
	input wire logic dp_rd_next
);
	import hbbls_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_read_answer: assert property ($fell(read_strobe_n) && !address_enable_in && write_strobe_n
		|=> host_data_bus_oe) else $error("read not answered");
	a_gated_read: assert property (address_enable_in && !host_data_bus_oe |=> !host_data_bus_oe)
		else $error("gated read answered");
	a_oe_release: assert property (host_data_bus_oe && read_strobe_n |=> !host_data_bus_oe)
		else $error("bus held after release");
	a_isa_pairing: assert property (host_data_bus_oe && bus_mode != HBBLS_MODE_PROC16
		&& !addr_bit5_burst_window_select |-> csr_hi_addr == (csr_lo_addr | 5'h01)) else $error("isa lanes");
	a_proc_pairing: assert property (host_data_bus_oe && bus_mode == HBBLS_MODE_PROC16
		&& !addr_bit5_burst_window_select |-> !csr_lo_addr[0] && csr_hi_addr == (csr_lo_addr | 5'h01))
		else $error("word lanes");
	a_reset_cause: assert property (device_reset |-> host_data_bus_oe && csr_hi_addr == OFF_DEV_RESET
		&& $past(read_strobe_n) == 1'h0) else $error("stray device reset");
	a_wr_on_release: assert property (csr_wr_en |-> $past(write_strobe_n) && !$past(write_strobe_n, 2))
		else $error("write pulse timing");
	a_dp_pop: assert property ($rose(read_strobe_n) && host_data_bus_oe && addr_bit5_burst_window_select
		|=> dp_rd_next) else $error("burst word not popped");
	c_burst: cover property (dp_rd_next && addr_bit5_burst_window_select);
	c_reset: cover property (device_reset);
	c_proc_wr: cover property (csr_wr_en && bus_mode == HBBLS_MODE_PROC16);
endmodule
bind hbbls_port hbbls_port_properties i_hbbls_port_properties (.*);

/* File: sim/tb_hbbls_port.sv */
// Bench for the host port: strap modes, lane steering, data port and reset offset.
// Assumes the register model answers combinationally.
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); fails++; end end
module tb_hbbls_port;
	import hbbls_pkg::*;
	logic clk_sys = 1'h0;
	logic arst_n = 1'h0;
	logic address_enable_in = 1'h0;
	logic read_strobe_n = 1'h1;
	logic write_strobe_n = 1'h1;
	logic eeprom_select_strap_pin = 1'h0;
	logic eeprom_clock_strap_pin = 1'h0;
	logic [5:0] a = 6'h00;
	logic [15:0] host_data_bus_in = 16'h0000;
	logic [15:0] host_data_bus_out, dp_rd_data, dp_wr_data;
	logic [7:0] csr_lo_data, csr_hi_data, csr_wr_data;
	logic [4:0] csr_lo_addr, csr_hi_addr, csr_wr_addr;
	logic host_data_bus_oe, csr_wr_en, dp_rd_next, dp_wr, device_reset;
	hbbls_mode_t bus_mode;
	hbbls_mode_t mode = HBBLS_MODE_ISA;
	int fails = 0;
	int check_count = 0;
	int dp_idx = 0;
	int cyc = 0;
	hbbls_port i_hbbls_port (.*, .host_addr_bit0_in(a[0]), .host_addr_mid(a[4:1]),
		.addr_bit5_burst_window_select(a[5]));
	hbbls_csr_model i_hbbls_csr_model (.*);
	initial forever #5 clk_sys = ~clk_sys;
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic boot(input logic s, input logic c, input hbbls_mode_t m);
		arst_n = 1'h0;
		eeprom_select_strap_pin = s;
		eeprom_clock_strap_pin = c;
		mode = m;
		dp_idx = 0;
		repeat (10) @(negedge clk_sys);
		arst_n = 1'h1;
		repeat (2) @(negedge clk_sys);
		`CHK("mode", m, bus_mode)
	endtask
	task automatic rd(input logic [5:0] n);
		logic dp;
		logic [15:0] e;
		dp = n == 6'h10 || n[5];
		e = {(n == 6'h1E) ? 8'h00 : {3'h5, n[4:1], 1'h1}, 3'h5, n[4:1], n[0] && mode != HBBLS_MODE_PROC16};
		if (dp)
			e = 16'hD000 + 16'(dp_idx);
		if (n == 6'h11)
			e = 16'h0000;
		a = n;
		read_strobe_n = 1'h0;
		// Answer and reset pulse are checked half a cycle after the taking edge
		@(negedge clk_sys);
		`CHK("rdata", {1'h1, e}, {host_data_bus_oe, host_data_bus_out})
		`CHK("reset", n == 6'h1F, device_reset)
		read_strobe_n = 1'h1;
		@(negedge clk_sys);
		`CHK("pop", dp, dp_rd_next)
		dp_idx += int'(dp);
		@(negedge clk_sys);
	endtask
	task automatic wr(input logic [5:0] n, input logic [15:0] d);
		logic [7:0] b;
		b = (mode == HBBLS_MODE_PROC16 && n[0]) ? d[15:8] : d[7:0];
		a = n;
		host_data_bus_in = d;
		write_strobe_n = 1'h0;
		@(negedge clk_sys);
		write_strobe_n = 1'h1;
		@(negedge clk_sys);
		if (n == 6'h10)
			`CHK("dp", {1'h1, d}, {dp_wr, dp_wr_data})
		else
			`CHK("csr", {2'h1, n[4:0], b}, {device_reset, csr_wr_en, csr_wr_addr, csr_wr_data})
		@(negedge clk_sys);
	endtask
	task automatic gated;
		address_enable_in = 1'h1;
		a = 6'h02;
		read_strobe_n = 1'h0;
		repeat (2) @(negedge clk_sys);
		`CHK("gated_oe", 1'h0, host_data_bus_oe)
		read_strobe_n = 1'h1;
		address_enable_in = 1'h0;
		@(negedge clk_sys);
	endtask
	task automatic scen_isa;
		boot(1'h0, 1'h0, HBBLS_MODE_ISA);
		rd(6'h02);
		rd(6'h03);
		rd(6'h10);
		rd(6'h11);
		rd(6'h1E);
		rd(6'h1F);
		rd(6'h20);
		rd(6'h2F);
		rd(6'h10);
		wr(6'h03, 16'hA55A);
		wr(6'h1F, 16'h1234);
		wr(6'h10, 16'hBEEF);
		gated;
	endtask
	task automatic scen_proc;
		boot(1'h0, 1'h1, HBBLS_MODE_PROC16);
		rd(6'h02);
		rd(6'h03);
		rd(6'h1F);
		rd(6'h10);
		wr(6'h02, 16'h1234);
		wr(6'h03, 16'h1234);
		wr(6'h1F, 16'hC3A5);
	endtask
	task automatic scen_mcu;
		boot(1'h1, 1'h1, HBBLS_MODE_MCU8);
		rd(6'h05);
		wr(6'h05, 16'h7E81);
		// Select strap alone falls back to ISA steering
		boot(1'h1, 1'h0, HBBLS_MODE_ISA);
		rd(6'h07);
	endtask
	initial begin
		scen_isa;
		scen_proc;
		scen_mcu;
		conclude;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			conclude;
		end
	end
endmodule
